// [prilk_arb.sv]
// oldest-stage-wins arbiter for a resource shared across stages
module prilk_arb (
   prilk_arb_if.arb a
);
   import prilk_pkg::*;

   // a higher stage index is further ahead, so it takes the grant
   genvar s;
   generate
      for (s = 0; s < NSTAGE - 1; s++) begin : g_grant
         assign a.grant[s] = a.req[s] & ~|a.req[NSTAGE-1:s+1];
      end
   endgenerate
   assign a.grant[NSTAGE-1] = a.req[NSTAGE-1];
endmodule

// [prilk_arb_if.sv]
// shared-resource request and grant lines between core and arbiter
interface prilk_arb_if;
   import prilk_pkg::*;
   logic [NSTAGE-1:0] req;
   logic [NSTAGE-1:0] grant;
   modport core (output req, input grant);
   modport arb  (input req, output grant);
endinterface

// [prilk_chk.sv]
// concurrent checks on the pipeline interlock ports
module prilk_chk (
   input  wire logic                                  mclk_i,
   input  wire logic                                  rst_n_i,
   input  wire logic                                  issue_valid_i,
   input  wire logic [prilk_pkg::TAG_W-1:0]           issue_tag_i,
   input  wire logic                                  issue_ready_o,
   input  wire logic [prilk_pkg::NSTAGE-1:0]          st_valid_o,
   input  wire logic [prilk_pkg::NSTAGE-1:0]          st_held_o,
   input  wire logic [prilk_pkg::NSTAGE*prilk_pkg::TAG_W-1:0] st_tag_o,
   input  wire logic                                  prefetch_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import prilk_pkg::*;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////////////////////////////////////
   take_enters_a: assert property (
      issue_valid_i && issue_ready_o |=>
      st_valid_o[0] && st_tag_o[7:0] == $past(issue_tag_i))
      else $error("taken issue missing from decode");
   refuse_holds_a: assert property (
      issue_valid_i && !issue_ready_o && st_valid_o[0] |=>
      st_held_o[0] && $stable(st_tag_o[7:0]))
      else $error("refused issue but decode not held");
   adv_ad_a: assert property (
      st_valid_o[1] ##1 !st_held_o[1] |->
      st_valid_o[2] && st_tag_o[23:16] == $past(st_tag_o[15:8]))
      else $error("address stage slot lost");
   adv_x_a: assert property (
      st_valid_o[5] ##1 !st_held_o[5] |->
      st_valid_o[6] && st_tag_o[55:48] == $past(st_tag_o[47:40]))
      else $error("execute stage slot lost");
   held_keep_a: assert property (
      st_held_o[4] |-> st_tag_o[39:32] == $past(st_tag_o[39:32]))
      else $error("held read stage changed its tag");
   chain_d_a: assert property (
      st_valid_o[0] ##1 st_held_o[1] |-> st_held_o[0])
      else $error("decode moved into a held address stage");
   bubble_ad_a: assert property (
      st_held_o[1] && !st_held_o[2] |-> !st_valid_o[2])
      else $error("no bubble ahead of held address stage");
   prefetch_src_a: assert property (
      prefetch_o |-> $past(st_valid_o[1]) && $past(st_valid_o[4]))
      else $error("prefetch without address and read overlap");
   write_free_a: assert property (
      !st_held_o[6])
      else $error("write stage held");
   cover property (prefetch_o);
   cover property (st_held_o[1] [*4]);
   cover property (st_held_o[4]);
   cover property (st_held_o[3]);
endmodule

bind prilk_core prilk_chk u_prilk_chk (.mclk_i, .rst_n_i, .issue_valid_i,
   .issue_tag_i, .issue_ready_o, .st_valid_o, .st_held_o, .st_tag_o,
   .prefetch_o);

// [prilk_core.sv]
// register interlock for the seven-stage execution pipeline
//
// What this block does
// - seven stages decode to write, one stage per cycle without stall.
// - on a resource conflict the instruction further ahead wins.
// - operands read in read stage, results written in execute stage.
// - indirect addressing reads and post-modifies pointers in address stage.
// - stack addressing and push/pop/call/return update stack pointer early.
// - address-modify writes pointers/temps in address stage, no stall after.
// - register swap of pointers/temps happens in address stage.
// - immediate loads of listed control registers complete in address stage.
// - stall write-read and read-write pairs so accesses keep program order.
// - execute-stage pointer write then address-stage use: 4 stall cycles.
// - four cycles of independent work between them remove that stall.
// - read-stage read then address-stage update: 2 stall cycles.
// - prefetch lets the reader see the old value in the update cycle.
// - each intervening instruction removes one of those stalls, up to two.
// - address-unit condition evaluation is fully interlocked.
// - long 32-bit operands cost nothing extra on single-access memory.
// - accumulator written in execute, memory-mapped read next: one stall.
module prilk_core (
   input  wire logic                                mclk_i,
   input  wire logic                                rst_n_i,
   input  wire logic                                issue_valid_i,
   input  wire prilk_pkg::prilk_op_e                issue_op_i,
   input  wire logic [prilk_pkg::REG_W-1:0]         issue_reg_a_i,
   input  wire logic [prilk_pkg::REG_W-1:0]         issue_reg_b_i,
   input  wire logic                                issue_mmap_i,
   input  wire logic                                issue_cond_ad_i,
   input  wire logic [prilk_pkg::REG_W-1:0]         issue_cond_reg_i,
   input  wire logic                                issue_res_i,
   input  wire logic [prilk_pkg::STG_W-1:0]         issue_res_stage_i,
   input  wire logic [prilk_pkg::TAG_W-1:0]         issue_tag_i,
   output logic                                     issue_ready_o,
   output logic [prilk_pkg::NSTAGE-1:0]             st_valid_o,
   output logic [prilk_pkg::NSTAGE-1:0]             st_held_o,
   output logic [prilk_pkg::NSTAGE*prilk_pkg::TAG_W-1:0] st_tag_o,
   output logic                                     prefetch_o
);
   import prilk_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic ad_imm_target(input logic [REG_W-1:0] r);
      return r inside {
         REG_CIRC_SIZE_LO,
         REG_CIRC_SIZE_HI,
         REG_CIRC_SIZE_COEF,
         REG_BLK_RPT_OUTER,
         REG_BLK_RPT_INNER,
         REG_SGL_RPT_COUNT,
         REG_DATA_PAGE_HIGH,
         REG_DATA_PAGE_EXT,
         REG_DATA_PAGE_PTR,
         REG_CIRC_START_01,
         REG_CIRC_START_23,
         REG_CIRC_START_45,
         REG_CIRC_START_67,
         REG_CIRC_START_COEF,
         REG_COEF_PTR,
         REG_DATA_STACK_PTR,
         REG_SYS_STACK_PTR
      };
   endfunction

   // one access of the younger slot meets one access of an older slot
   function automatic logic reg_hit(
      input logic             v_yng,
      input logic [REG_W-1:0] r_yng,
      input logic             v_old,
      input logic [REG_W-1:0] r_old
   );
      return v_yng && v_old && r_yng == r_old;
   endfunction

   function automatic prilk_slot_s decode_slot(
      input prilk_op_e        op,
      input logic [REG_W-1:0] ra,
      input logic [REG_W-1:0] rb,
      input logic             mmap,
      input logic             cond_ad,
      input logic [REG_W-1:0] cond_reg,
      input logic             res,
      input logic [STG_W-1:0] res_stage,
      input logic [TAG_W-1:0] tag
   );
      prilk_slot_s s;
      s           = SLOT_EMPTY;
      s.valid     = 1'b1;
      s.tag       = tag;
      // one booking per instruction, whatever the operand width
      s.res_v     = res;
      s.res_stage = res_stage;
      // condition sources are checked like address-stage reads
      s.ad_rd_v[2] = cond_ad;
      s.ad_rd[2]   = cond_reg;
      unique case (op)
         OP_ALU: begin
            s.r_rd_v = 1'b1;
            s.r_rd   = rb;
            s.r_mm   = mmap;
            s.x_wr_v = 1'b1;
            s.x_wr   = ra;
         end
         OP_MOVE: begin
            // internal bus: read in R, but not a memory-mapped access
            s.r_rd_v = 1'b1;
            s.r_rd   = rb;
            s.x_wr_v = 1'b1;
            s.x_wr   = ra;
         end
         OP_INDIRECT: begin
            s.ad_rd_v[0] = 1'b1;
            s.ad_rd[0]   = ra;
            s.ad_wr_v[0] = 1'b1;
            s.ad_wr[0]   = ra;
            s.x_wr_v     = 1'b1;
            s.x_wr       = rb;
         end
         OP_STACK: begin
            s.ad_rd_v[0] = 1'b1;
            s.ad_rd[0]   = REG_DATA_STACK_PTR;
            s.ad_wr_v[0] = 1'b1;
            s.ad_wr[0]   = REG_DATA_STACK_PTR;
         end
         OP_MODIFY: begin
            // dedicated address hardware, done before any later user
            s.ad_wr_v[0] = 1'b1;
            s.ad_wr[0]   = ra;
         end
         OP_SWAP: begin
            s.ad_rd_v[1:0] = 2'b11;
            s.ad_rd[0]     = ra;
            s.ad_rd[1]     = rb;
            s.ad_wr_v      = 2'b11;
            s.ad_wr[0]     = ra;
            s.ad_wr[1]     = rb;
         end
         OP_LOAD_IMM: begin
            if (ad_imm_target(ra)) begin
               s.ad_wr_v[0] = 1'b1;
               s.ad_wr[0]   = ra;
            end else begin
               s.x_wr_v = 1'b1;
               s.x_wr   = ra;
            end
         end
         default: begin
            s.valid = 1'b0;
         end
      endcase
      return s;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // shared-resource arbitration

   prilk_arb_if arb_bus ();

   prilk_arb u_arb (
      .a (arb_bus.arb)
   );

   prilk_slot_s pipe_q [NSTAGE];
   prilk_slot_s pipe_d [NSTAGE];
   logic [NSTAGE-1:0] held_q;
   logic [NSTAGE-1:0] held_d;
   logic              prefetch_q;
   logic              prefetch_d;
   logic [NSTAGE-1:0] own;
   logic [NSTAGE-1:0] hold;
   logic [NSTAGE-1:0] req;

   always_comb begin
      for (int s = 0; s < NSTAGE; s++) begin
         req[s] = pipe_q[s].valid && pipe_q[s].res_v &&
                  pipe_q[s].res_stage == STG_W'(s);
      end
   end
   assign arb_bus.req = req;

   ////////////////////////////////////////////////////////////////////////
   // hazard detection and advance

   always_comb begin
      prilk_slot_s ad;
      prilk_slot_s o;
      ad         = pipe_q[ST_AD];
      o          = SLOT_EMPTY;
      own        = '0;
      prefetch_d = 1'b0;
      // address-stage reader against older execute-stage writers
      // a writer still in X has not written yet, so X is in the range
      for (int j = ST_AC1; j <= ST_X; j++) begin
         o = pipe_q[j];
         for (int k = 0; k < NRD_AD; k++) begin
            if (ad.valid && o.valid &&
                reg_hit(ad.ad_rd_v[k], ad.ad_rd[k], o.x_wr_v, o.x_wr)) begin
               own[ST_AD] = 1'b1;
            end
         end
      end
      // address-stage updater waits until older readers reach R
      // a reader already in R takes the old value by prefetch, so R is out
      for (int j = ST_AC1; j <= ST_AC2; j++) begin
         o = pipe_q[j];
         for (int k = 0; k < NWR_AD; k++) begin
            if (ad.valid && o.valid &&
                reg_hit(ad.ad_wr_v[k], ad.ad_wr[k], o.r_rd_v, o.r_rd)) begin
               own[ST_AD] = 1'b1;
            end
         end
      end
      // memory-mapped read right behind an execute write
      // a move over internal buses never sets r_mm, so it passes freely
      if (pipe_q[ST_R].valid && pipe_q[ST_R].r_rd_v && pipe_q[ST_R].r_mm &&
          pipe_q[ST_X].valid && pipe_q[ST_X].x_wr_v &&
          pipe_q[ST_X].x_wr == pipe_q[ST_R].r_rd) begin
         own[ST_R] = 1'b1;
      end
      // losers of the shared resource wait where they are
      own = own | (req & ~arb_bus.grant);
      // a stall holds itself and everything younger
      // no squeezing into an empty slot ahead: simpler, may cost a cycle
      hold[ST_W] = own[ST_W];
      for (int s = ST_X; s >= ST_D; s--) begin
         hold[s] = own[s] | hold[s+1];
      end
      // same-cycle update and read: the reader takes the old value
      for (int k = 0; k < NWR_AD; k++) begin
         if (!hold[ST_AD] && ad.valid && ad.ad_wr_v[k] &&
             pipe_q[ST_R].valid && pipe_q[ST_R].r_rd_v &&
             pipe_q[ST_R].r_rd == ad.ad_wr[k]) begin
            prefetch_d = 1'b1;
         end
      end
      // advance: held stages keep, ahead of a hold a bubble appears
      for (int s = ST_W; s >= ST_AD; s--) begin
         if (hold[s]) begin
            pipe_d[s] = pipe_q[s];
         end else if (hold[s-1]) begin
            pipe_d[s] = SLOT_EMPTY;
         end else begin
            pipe_d[s] = pipe_q[s-1];
         end
      end
      if (hold[ST_D]) begin
         pipe_d[ST_D] = pipe_q[ST_D];
      end else if (issue_valid_i) begin
         pipe_d[ST_D] = decode_slot(issue_op_i, issue_reg_a_i,
                                    issue_reg_b_i, issue_mmap_i,
                                    issue_cond_ad_i, issue_cond_reg_i,
                                    issue_res_i, issue_res_stage_i,
                                    issue_tag_i);
      end else begin
         pipe_d[ST_D] = SLOT_EMPTY;
      end
      // only stages that carry an instruction report a hold
      for (int s = 0; s < NSTAGE; s++) begin
         held_d[s] = hold[s] & pipe_q[s].valid;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int s = 0; s < NSTAGE; s++) begin
            pipe_q[s] <= SLOT_EMPTY;
         end
         held_q     <= '0;
         prefetch_q <= 1'b0;
      end else begin
         for (int s = 0; s < NSTAGE; s++) begin
            pipe_q[s] <= pipe_d[s];
         end
         held_q     <= held_d;
         prefetch_q <= prefetch_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   // the issue handshake must see this cycle's stall, so it is not flopped
   assign issue_ready_o = ~hold[ST_D];
   assign st_held_o     = held_q;
   assign prefetch_o    = prefetch_q;

   genvar g;
   generate
      for (g = 0; g < NSTAGE; g++) begin : g_out
         assign st_valid_o[g]                 = pipe_q[g].valid;
         assign st_tag_o[g*TAG_W +: TAG_W]    = pipe_q[g].tag;
      end
   endgenerate
endmodule

// [prilk_pkg.sv]
// constants, register ids and slot layout for the pipeline interlock
package prilk_pkg;

   ////////////////////////////////////////////////////////////////////////
   // pipeline geometry
   localparam int NSTAGE  = 7;
   localparam int ST_D    = 0;
   localparam int ST_AD   = 1;
   localparam int ST_AC1  = 2;
   localparam int ST_AC2  = 3;
   localparam int ST_R    = 4;
   localparam int ST_X    = 5;
   localparam int ST_W    = 6;
   localparam int STG_W   = 3;
   localparam int REG_W   = 6;
   localparam int TAG_W   = 8;
   localparam int NRD_AD  = 3;
   localparam int NWR_AD  = 2;

   ////////////////////////////////////////////////////////////////////////
   // cpu register ids, pointers 0..7 sit at 6'h00..6'h07
   localparam logic [REG_W-1:0] REG_PTR_BASE        = 6'h00;
   localparam logic [REG_W-1:0] REG_COEF_PTR        = 6'h08;
   localparam logic [REG_W-1:0] REG_DATA_STACK_PTR  = 6'h09;
   localparam logic [REG_W-1:0] REG_SYS_STACK_PTR   = 6'h0a;
   localparam logic [REG_W-1:0] REG_CIRC_SIZE_LO    = 6'h0b;
   localparam logic [REG_W-1:0] REG_CIRC_SIZE_HI    = 6'h0c;
   localparam logic [REG_W-1:0] REG_CIRC_SIZE_COEF  = 6'h0d;
   localparam logic [REG_W-1:0] REG_BLK_RPT_OUTER   = 6'h0e;
   localparam logic [REG_W-1:0] REG_BLK_RPT_INNER   = 6'h0f;
   localparam logic [REG_W-1:0] REG_SGL_RPT_COUNT   = 6'h10;
   localparam logic [REG_W-1:0] REG_DATA_PAGE_HIGH  = 6'h11;
   localparam logic [REG_W-1:0] REG_DATA_PAGE_EXT   = 6'h12;
   localparam logic [REG_W-1:0] REG_DATA_PAGE_PTR   = 6'h13;
   localparam logic [REG_W-1:0] REG_CIRC_START_01   = 6'h14;
   localparam logic [REG_W-1:0] REG_CIRC_START_23   = 6'h15;
   localparam logic [REG_W-1:0] REG_CIRC_START_45   = 6'h16;
   localparam logic [REG_W-1:0] REG_CIRC_START_67   = 6'h17;
   localparam logic [REG_W-1:0] REG_CIRC_START_COEF = 6'h18;

   ////////////////////////////////////////////////////////////////////////
   // instruction classes as seen by the interlock
   typedef enum logic [2:0] {
      OP_ALU      = 3'b000,
      OP_MOVE     = 3'b001,
      OP_INDIRECT = 3'b010,
      OP_STACK    = 3'b011,
      OP_MODIFY   = 3'b100,
      OP_SWAP     = 3'b101,
      OP_LOAD_IMM = 3'b110
   } prilk_op_e;

   // what one instruction touches and in which stage
   typedef struct packed {
      logic                           valid;
      logic [TAG_W-1:0]               tag;
      logic [NRD_AD-1:0]              ad_rd_v;
      logic [NRD_AD-1:0][REG_W-1:0]   ad_rd;
      logic [NWR_AD-1:0]              ad_wr_v;
      logic [NWR_AD-1:0][REG_W-1:0]   ad_wr;
      logic                           r_rd_v;
      logic                           r_mm;
      logic [REG_W-1:0]               r_rd;
      logic                           x_wr_v;
      logic [REG_W-1:0]               x_wr;
      logic                           res_v;
      logic [STG_W-1:0]               res_stage;
   } prilk_slot_s;

   localparam prilk_slot_s SLOT_EMPTY = '0;

endpackage

// [prilk_src.sv]
// instruction stream model standing in for decode and dispatch
module prilk_src (
   input  wire logic                        mclk_i,
   input  wire logic                        rst_n_i,
   input  wire logic                        ready_i,
   output logic                             valid_o,
   output prilk_pkg::prilk_op_e             op_o,
   output logic [prilk_pkg::REG_W-1:0]      a_o,
   output logic [prilk_pkg::REG_W-1:0]      b_o,
   output logic                             mmap_o,
   output logic                             res_o,
   output logic [prilk_pkg::STG_W-1:0]      rstg_o,
   output logic [prilk_pkg::TAG_W-1:0]      tag_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import prilk_pkg::*;
   typedef struct packed {
      prilk_op_e  op;
      logic [5:0] a;
      logic [5:0] b;
      logic       m;
      logic       r;
      logic [2:0] s;
      logic [7:0] t;
   } prilk_ins_s;
   prilk_ins_s q[$];
   prilk_ins_s cur;
   // stream never touches loop or repeat state
   task automatic push(input prilk_ins_s i);
      q.push_back(i);
   endtask
   // refused words stay put until taken; idle register and tag lines toggle, not hold
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         op_o <= OP_ALU;
         {a_o, b_o, mmap_o, res_o, rstg_o, tag_o} <= '0;
         valid_o <= 1'b0;
      end else if (!valid_o || ready_i) begin
         if (q.size() > 0) begin
            cur = q.pop_front();
            op_o <= cur.op;
            {a_o, b_o, mmap_o, res_o, rstg_o, tag_o} <=
               {cur.a, cur.b, cur.m, cur.r, cur.s, cur.t};
            valid_o <= 1'b1;
         end else begin
            valid_o <= 1'b0;
            a_o <= ~a_o;
            b_o <= ~b_o;
            tag_o <= ~tag_o;
         end
      end
   end
endmodule

// [tb_top.sv]
// self-checking bench for the pipeline interlock
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import prilk_pkg::*;
   logic                 mclk_i = 1'b0;
   logic                 rst_n_i;
   logic                 issue_valid_i;
   prilk_op_e            issue_op_i;
   logic [REG_W-1:0]     issue_reg_a_i;
   logic [REG_W-1:0]     issue_reg_b_i;
   logic                 issue_mmap_i;
   logic                 issue_cond_ad_i = 1'b0;
   logic [REG_W-1:0]     issue_cond_reg_i = 6'h3f;
   logic                 issue_res_i;
   logic [STG_W-1:0]     issue_res_stage_i;
   logic [TAG_W-1:0]     issue_tag_i;
   logic                 issue_ready_o;
   logic [NSTAGE-1:0]    st_valid_o;
   logic [NSTAGE-1:0]    st_held_o;
   logic [NSTAGE*TAG_W-1:0] st_tag_o;
   logic                 prefetch_o;
   int                   num_errors = 0;
   int                   n_checks = 0;
   int                   h[NSTAGE];
   int                   pf_n;
   int                   w_n;
   logic [TAG_W-1:0]     w_tag;
   int                   cyc = 0;
   logic [7:0]           tg = 8'h01;

   prilk_core u_prilk_core (.*);
   prilk_src u_prilk_src (.mclk_i, .rst_n_i, .ready_i(issue_ready_o),
      .valid_o(issue_valid_i), .op_o(issue_op_i), .a_o(issue_reg_a_i),
      .b_o(issue_reg_b_i), .mmap_o(issue_mmap_i), .res_o(issue_res_i),
      .rstg_o(issue_res_stage_i), .tag_o(issue_tag_i));

   always #20 mclk_i = ~mclk_i;
   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         end_sim();
      end
   end
   task automatic chk(input string w, input logic [31:0] e,
                      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %0d seen %0d", w, e, g);
      end
   endtask
   task automatic ins(input prilk_op_e op, input logic [5:0] a, b,
                      input logic m = 1'b0, r = 1'b0,
                      input logic [2:0] s = 3'h7);
      u_prilk_src.push({op, a, b, m, r, s, tg});
      tg++;
   endtask
   task automatic nop();
      ins(OP_ALU, 6'h31, 6'h32);
   endtask
   // counts holds, prefetch pulses and retirements over n cycles
   task automatic run(input int n);
      h = '{default: 0};
      pf_n = 0;
      w_n = 0;
      repeat (n) begin
         @(posedge mclk_i);
         #1;
         for (int s = 0; s < NSTAGE; s++) if (st_held_o[s] === 1'b1) h[s]++;
         if (prefetch_o === 1'b1) pf_n++;
         if (st_valid_o[6] === 1'b1) begin
            w_n++;
            w_tag = st_tag_o[ST_W*TAG_W +: TAG_W];
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_wr_ptr();
      for (int k = 0; k <= 4; k++) begin
         ins(OP_ALU, 6'h01, 6'h30);
         repeat (k) nop();
         ins(OP_INDIRECT, 6'h01, 6'h33);
         ins(OP_ALU, 6'h34, 6'h35);
         run(30);
         chk("ad hold", 4 - k, h[1]);
         if (k == 0) chk("d hold", 4, h[0]);
         chk("retired", k + 3, w_n);
         chk("last tag", tg - 8'h01, w_tag);
      end
      $display("test wr_ptr done");
   endtask
   task automatic t_rd_ptr();
      for (int k = 0; k <= 3; k++) begin
         ins(OP_MOVE, 6'h30, 6'h01);
         repeat (k) nop();
         ins(OP_INDIRECT, 6'h01, 6'h33);
         run(30);
         chk("ad hold", (k < 2) ? 2 - k : 0, h[1]);
         if (k == 0) chk("prefetch", 1, pf_n);
      end
      $display("test rd_ptr done");
   endtask
   task automatic t_ad_early();
      prilk_op_e  op[6] = '{OP_MODIFY, OP_LOAD_IMM, OP_LOAD_IMM, OP_SWAP,
                            OP_INDIRECT, OP_STACK};
      logic [5:0] ra[6] = '{6'h01, REG_COEF_PTR, 6'h01, 6'h03, 6'h01, 6'h01};
      logic [5:0] ru[6] = '{6'h01, REG_COEF_PTR, 6'h01, 6'h02, 6'h01,
                            REG_DATA_STACK_PTR};
      int         ex[6] = '{0, 0, 4, 0, 0, 0};
      for (int i = 0; i < 6; i++) begin
         ins(op[i], ra[i], 6'h02);
         ins(OP_INDIRECT, ru[i], 6'h33);
         run(30);
         chk("early ad hold", ex[i], h[1]);
      end
      $display("test ad_early done");
   endtask
   task automatic t_acc();
      for (int i = 0; i < 3; i++) begin
         ins(OP_ALU, 6'h20, 6'h21);
         ins((i == 2) ? OP_MOVE : OP_ALU, 6'h22, 6'h20, i == 1);
         run(30);
         chk("r hold", (i == 1) ? 1 : 0, h[4]);
      end
      $display("test acc done");
   endtask
   task automatic t_res();
      ins(OP_ALU, 6'h30, 6'h31, 1'b0, 1'b1, 3'h4);
      ins(OP_ALU, 6'h32, 6'h33, 1'b0, 1'b1, 3'h3);
      run(30);
      chk("loser hold", 1, h[3]);
      chk("winner hold", 0, h[4]);
      $display("test res done");
   endtask
   task automatic t_cond();
      @(posedge mclk_i);
      issue_cond_ad_i  <= 1'b1;
      issue_cond_reg_i <= 6'h05;
      ins(OP_ALU, 6'h05, 6'h30);
      nop();
      run(30);
      chk("cond hold", 4, h[1]);
      @(posedge mclk_i);
      issue_cond_ad_i <= 1'b0;
      $display("test cond done");
   endtask
   task automatic t_reset();
      repeat (3) nop();
      run(3);
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      run(2);
      chk("valid in reset", 0, st_valid_o);
      chk("ready in reset", 1, issue_ready_o);
      @(posedge mclk_i);
      rst_n_i <= 1'b1;
      nop();
      run(20);
      chk("retired after reset", 1, w_n);
      $display("test reset done");
   endtask
   initial begin
      rst_n_i = 1'b0;
      repeat (10) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      t_wr_ptr();
      t_rd_ptr();
      t_ad_early();
      t_acc();
      t_res();
      t_cond();
      t_reset();
      end_sim();
   end
endmodule
